// *** rtl/tmr_pkg.sv ***
// Constants, field layout and decode helpers for the 16-bit timer.
// Assumes a single system clock and word-addressed register port.
package tmr_pkg;

   // Counter width and extremes
   localparam int unsigned CNT_W = 16;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // Register word addresses
   localparam logic [2:0] ADDR_TIMER_MODE = 3'h0;
   localparam logic [2:0] ADDR_CAP_CMP_CTRL = 3'h1;
   localparam logic [2:0] ADDR_PRESCALER = 3'h2;
   localparam logic [2:0] ADDR_CMP_CAP_A = 3'h3;
   localparam logic [2:0] ADDR_CAPTURE_B = 3'h4;
   localparam logic [2:0] ADDR_COUNTER = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h6;

   // Timer mode field codes
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_FREE = 2'h1;
   localparam logic [1:0] MODE_CLEAR = 2'h2;

   // Capture/compare control bit positions
   localparam int unsigned CCC_A_CAPTURE = 0;
   localparam int unsigned CCC_B_ENABLE = 1;

   // Prescaler register layout and reset value
   localparam int unsigned PRM_CLK_LSB = 0;
   localparam int unsigned PRM_EDGE_A_LSB = 4;
   localparam int unsigned PRM_EDGE_B_LSB = 6;
   localparam logic [7:0] PRM_WMASK = 8'hF3;
   localparam logic [7:0] PRM_RESET = 8'h00;

   // Count clock selections
   localparam logic [1:0] CLK_FXP = 2'h0;
   localparam logic [1:0] CLK_DIV4 = 2'h1;
   localparam logic [1:0] CLK_DIV256 = 2'h2;
   localparam logic [1:0] CLK_EDGE_A = 2'h3;
   localparam logic [7:0] DIV4_MASK = 8'h03;
   localparam logic [7:0] DIV256_MASK = 8'hFF;

   // Edge selection codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Status bit position
   localparam int unsigned STAT_OVF = 0;

   // Edge qualification by select code; the forbidden code never fires
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       rise,
                                     input logic       fall);
      logic hit;
      hit = 1'b0;
      case (sel)
         EDGE_FALL: hit = fall;
         EDGE_RISE: hit = rise;
         EDGE_BOTH: hit = rise | fall;
         default:   hit = 1'b0;
      endcase
      return hit;
   endfunction

endpackage

// *** rtl/tmr_edge_if.sv ***
// Link between the timer core and one input edge filter.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface tmr_edge_if;
   logic       sample_en;
   logic       enable;
   logic [1:0] edge_sel;
   logic       valid_edge;

   // Filter end
   modport filt (input sample_en, input enable, input edge_sel, output valid_edge);
   // Timer core end
   modport core (output sample_en, output enable, output edge_sel, input valid_edge);
endinterface
`default_nettype wire

// *** rtl/tmr_edge_filter.sv ***
// Pin synchroniser, two-sample noise filter and edge qualifier.
// Assumes the pin is asynchronous to clk_sys; sample_en paces sampling.
`timescale 1ns/1ps
`default_nettype none
module tmr_edge_filter
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic pin,
   tmr_edge_if.filt  link
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic stable;
      logic hist;
      logic filt;
      logic edge_out;
   } tmr_filt_type;

   tmr_filt_type st;
   tmr_filt_type next_st;

   // Synchronise, filter and qualify
   always_comb
   begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.edge_out = 1'b0;
      if (st.s2 == st.s3)
      begin
         next_st.stable = st.s3;
      end
      // Level must be seen on two successive samples
      if (link.enable && link.sample_en)
      begin
         next_st.hist = st.stable;
         if (st.stable == st.hist)
         begin
            next_st.filt = st.stable;
         end
      end
      // Rising and falling transitions of the filtered level
      next_st.edge_out = tmr_pkg::edge_hit(link.edge_sel,
                                           next_st.filt & ~st.filt,
                                           st.filt & ~next_st.filt);
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign link.valid_edge = st.edge_out;

endmodule
`default_nettype wire

// *** rtl/tmr_timer16.sv ***
// 16-bit interval timer, event counter and pulse width capture unit.
// Assumes a word-addressed register port on clk_sys and async input pins.
//
// What this block does
// - Interval match clears counter, raises compare-A request
// - Count clock chosen by prescaler bits 0-1
// - Compare modes flag overflow only at FFFFH
// - Interval lasts N plus one count periods
// - Lowered compare: count through wrap, restart
// - Event mode counts each valid input-A edge
// - Event match clears counter, raises compare-A request
// - Input-A edge chosen by prescaler bits 4-5
// - Codes: 00 fall, 01 rise, 11 both
// - Event edges need valid level sampled twice
// - After start, counting waits for double detection
// - Captures sampled at count clock (fxp when input A clocks), level twice
// - Overflow flag cleared only by software
// - Free-running: input-A edge captures into B
// - Input-B edge captures into A, raises request
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16
#(
   parameter int unsigned DATA_WIDTH = 16
)
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        event_input_a,
   input  wire logic        capture_input_b,
   output logic             compare_a_irq,
   output logic             capture_b_irq,
   output logic             overflow_flag
);

   // Refuse widths that the counter logic does not serve
   if (DATA_WIDTH != tmr_pkg::CNT_W)
   begin : g_width_check
      $error("tmr_timer16 supports only a 16-bit data width");
   end

   // Clock and edge fields must fit the 8-bit prescaler word
   if ((tmr_pkg::PRM_EDGE_B_LSB + 2) > 8)
   begin : g_field_check
      $error("tmr_timer16 prescaler fields exceed the register");
   end

   // Reset value must not set bits that software cannot write
   if ((tmr_pkg::PRM_RESET & ~tmr_pkg::PRM_WMASK) != 8'h00)
   begin : g_reset_check
      $error("tmr_timer16 prescaler reset value sets reserved bits");
   end

   // Complete block state, registered as one word
   typedef struct packed {
      logic [1:0]  mode;
      logic        a_capture;
      logic        b_enable;
      logic [7:0]  prescaler;
      logic [15:0] cmp_a;
      logic [15:0] cap_b;
      logic [15:0] counter;
      logic        ovf;
      logic [7:0]  div;
      logic        irq_a;
      logic        irq_b;
      logic [15:0] rdata;
   } tmr_state_type;

   // Present and next state
   tmr_state_type st;
   tmr_state_type next_st;

   // Links to the two pin filters
   tmr_edge_if edge_a_if ();
   tmr_edge_if edge_b_if ();

   // Decoded control, ticks and events
   logic [1:0] clk_sel;
   logic       running;
   logic       presc_tick;
   logic       sample_a;
   logic       count_tick;
   logic       edge_a;
   logic       edge_b;
   logic       compare_on;
   logic       ext_clock;
   logic       match_hit;
   logic       wrap_hit;
   logic       ovf_set;
   logic       capture_b_hit;
   logic       capture_a_hit;

   // Control decode
   assign clk_sel = st.prescaler[tmr_pkg::PRM_CLK_LSB +: 2];
   // Mode code 3 behaves as stop
   assign running = (st.mode == tmr_pkg::MODE_FREE) ||
                    (st.mode == tmr_pkg::MODE_CLEAR);
   assign ext_clock = (clk_sel == tmr_pkg::CLK_EDGE_A);
   assign compare_on = (st.mode == tmr_pkg::MODE_CLEAR) && !st.a_capture;
   // Qualified edges from the filters
   assign edge_a = edge_a_if.valid_edge;
   assign edge_b = edge_b_if.valid_edge;

   // Internal count clock from the prescaler divider
   always_comb
   begin
      presc_tick = 1'b0;
      unique case (clk_sel)
         tmr_pkg::CLK_FXP:
         begin
            // Every system clock
            presc_tick = 1'b1;
         end
         tmr_pkg::CLK_DIV4:
         begin
            // Low two divider bits all ones
            presc_tick = ((st.div & tmr_pkg::DIV4_MASK) == tmr_pkg::DIV4_MASK);
         end
         tmr_pkg::CLK_DIV256:
         begin
            // Whole divider all ones
            presc_tick = ((st.div & tmr_pkg::DIV256_MASK) == tmr_pkg::DIV256_MASK);
         end
         tmr_pkg::CLK_EDGE_A:
         begin
            // Filters sample at fxp; edges pace the count
            presc_tick = 1'b1;
         end
      endcase
   end

   // Event counting samples input A at fxp; capture at the count clock
   assign sample_a = ext_clock ? 1'b1 : presc_tick;

   // Count tick: prescaled clock or qualified input-A edge
   assign count_tick = running && (ext_clock ? edge_a : presc_tick);

   // Compare match and free-run wrap on a count tick
   assign match_hit = count_tick && compare_on && (st.counter == st.cmp_a);
   assign wrap_hit = count_tick && (st.mode == tmr_pkg::MODE_FREE) &&
                     (st.counter == tmr_pkg::CNT_MAX);

   // Overflow only on a full-range match or a free-run wrap
   assign ovf_set = (match_hit && (st.cmp_a == tmr_pkg::CNT_MAX)) || wrap_hit;

   // Capture strobes; input-A capture is off while A clocks the count
   assign capture_b_hit = running && st.b_enable && edge_a && !ext_clock;
   assign capture_a_hit = running && st.a_capture && edge_b;

   // Drive the filter links
   assign edge_a_if.sample_en = sample_a;
   assign edge_a_if.enable = running;
   assign edge_a_if.edge_sel = st.prescaler[tmr_pkg::PRM_EDGE_A_LSB +: 2];
   assign edge_b_if.sample_en = presc_tick;
   assign edge_b_if.enable = running;
   assign edge_b_if.edge_sel = st.prescaler[tmr_pkg::PRM_EDGE_B_LSB +: 2];

   // Input A filter
   tmr_edge_filter u_filter_a
   (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (event_input_a),
      .link    (edge_a_if.filt)
   );

   // Input B filter
   tmr_edge_filter u_filter_b
   (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (capture_input_b),
      .link    (edge_b_if.filt)
   );

   // Next-state logic: register port, counter, captures
   always_comb
   begin
      next_st = st;
      next_st.irq_a = 1'b0;
      next_st.irq_b = 1'b0;
      // Read data rest at zero between reads
      next_st.rdata = 16'h0000;

      // Register reads answer in the following cycle
      if (reg_rd)
      begin
         unique case (reg_addr)
            tmr_pkg::ADDR_TIMER_MODE:
            begin
               next_st.rdata = {14'h0000, st.mode};
            end
            tmr_pkg::ADDR_CAP_CMP_CTRL:
            begin
               next_st.rdata = {14'h0000, st.b_enable, st.a_capture};
            end
            tmr_pkg::ADDR_PRESCALER:
            begin
               next_st.rdata = {8'h00, st.prescaler};
            end
            tmr_pkg::ADDR_CMP_CAP_A:
            begin
               next_st.rdata = st.cmp_a;
            end
            tmr_pkg::ADDR_CAPTURE_B:
            begin
               next_st.rdata = st.cap_b;
            end
            tmr_pkg::ADDR_COUNTER:
            begin
               // Event count comes straight from the counter
               next_st.rdata = st.counter;
            end
            tmr_pkg::ADDR_STATUS:
            begin
               // Only the overflow bit is defined
               next_st.rdata = {15'h0000, st.ovf};
            end
            default:
            begin
               next_st.rdata = 16'h0000;
            end
         endcase
      end

      // Register writes
      if (reg_wr)
      begin
         unique case (reg_addr)
            tmr_pkg::ADDR_TIMER_MODE:
            begin
               next_st.mode = reg_wdata[1:0];
            end
            tmr_pkg::ADDR_CAP_CMP_CTRL:
            begin
               next_st.a_capture = reg_wdata[tmr_pkg::CCC_A_CAPTURE];
               next_st.b_enable = reg_wdata[tmr_pkg::CCC_B_ENABLE];
            end
            tmr_pkg::ADDR_PRESCALER:
            begin
               // Reserved bits 2 and 3 stay zero
               next_st.prescaler = reg_wdata[7:0] & tmr_pkg::PRM_WMASK;
            end
            tmr_pkg::ADDR_CMP_CAP_A:
            begin
               // May be rewritten while counting
               next_st.cmp_a = reg_wdata;
            end
            tmr_pkg::ADDR_STATUS:
            begin
               // Write one clears; hardware set below wins
               if (reg_wdata[tmr_pkg::STAT_OVF])
               begin
                  next_st.ovf = 1'b0;
               end
            end
            default:
            begin
               next_st.mode = st.mode;
            end
         endcase
      end

      // Stopped timer holds counter and divider at zero
      if (!running)
      begin
         next_st.counter = tmr_pkg::CNT_ZERO;
         next_st.div = 8'h00;
      end
      else
      begin
         next_st.div = st.div + 8'h01;
         if (match_hit)
         begin
            // Match: clear and request; period is N plus one ticks
            next_st.counter = tmr_pkg::CNT_ZERO;
            next_st.irq_a = 1'b1;
         end
         else if (count_tick)
         begin
            // Past a lowered compare the count wraps silently
            next_st.counter = st.counter + 16'h0001;
         end
      end

      // Input-A edge captures the counter into B
      if (capture_b_hit)
      begin
         next_st.cap_b = st.counter;
         next_st.irq_b = 1'b1;
      end

      // Input-B edge captures the counter into A, over a software write
      if (capture_a_hit)
      begin
         next_st.cmp_a = st.counter;
         next_st.irq_a = 1'b1;
      end

      // Hardware set of the overflow flag wins over a software clear
      if (ovf_set)
      begin
         next_st.ovf = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         st <= '0;
         // Prescaler takes its own reset value
         st.prescaler <= tmr_pkg::PRM_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = st.rdata;
   assign compare_a_irq = st.irq_a;
   assign capture_b_irq = st.irq_b;
   assign overflow_flag = st.ovf;

endmodule
`default_nettype wire

// *** verif/tmr_asserts.sv ***
// Port checker for the timer top.
// Assumes it is bound to tmr_timer16 and shadows control writes itself.
`timescale 1ns/1ps
`default_nettype none
module tmr_asserts
(
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic [2:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        compare_a_irq,
   input wire logic        capture_b_irq,
   input wire logic        overflow_flag
);
   logic [1:0]  mode;
   logic [1:0]  ctrl;
   logic [15:0] cmp;
   logic [3:0]  age;
   logic        ovf_clr;
   logic        stopped;
   // Software clear and stopped state
   assign ovf_clr = reg_wr && reg_addr == tmr_pkg::ADDR_STATUS && reg_wdata[0];
   assign stopped = mode == tmr_pkg::MODE_STOP || mode == 2'h3;
   // Shadow of control writes, age counts quiet cycles since the last one
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         mode <= 2'h0;
         ctrl <= 2'h0;
         cmp  <= 16'h0000;
         age  <= 4'h0;
      end
      else if (reg_wr && reg_addr < 3'h4)
      begin
         if (reg_addr == tmr_pkg::ADDR_TIMER_MODE) mode <= reg_wdata[1:0];
         if (reg_addr == tmr_pkg::ADDR_CAP_CMP_CTRL) ctrl <= reg_wdata[1:0];
         if (reg_addr == tmr_pkg::ADDR_CMP_CAP_A) cmp <= reg_wdata;
         age <= 4'h0;
      end
      else if (age != 4'hF)
         age <= age + 4'h1;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_stat_read;
      reg_rd && reg_addr == tmr_pkg::ADDR_STATUS;
   endsequence
   sequence s_settled;
      age == 4'hF;
   endsequence
   chk_irq_a_pulse:
      assert property (compare_a_irq |=> !compare_a_irq)
      else $error("compare request held too long");
   chk_irq_b_pulse:
      assert property ($rose(capture_b_irq) |=> $fell(capture_b_irq))
      else $error("capture request held too long");
   chk_ovf_sticky:
      assert property (overflow_flag && !ovf_clr |=> overflow_flag)
      else $error("overflow dropped without clear");
   chk_stat_read:
      assert property (s_stat_read |=> reg_rdata[0] == $past(overflow_flag)
                       && reg_rdata[15:1] == 15'h0000)
      else $error("status read wrong");
   chk_rdata_idle:
      assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data without read");
   chk_stop_quiet:
      assert property ((age == 4'hF && stopped) [*2] |-> !compare_a_irq && !capture_b_irq)
      else $error("request while stopped");
   chk_ovf_compare:
      assert property (s_settled ##0 (mode == tmr_pkg::MODE_CLEAR && !ctrl[0]
                       && cmp != tmr_pkg::CNT_MAX && !overflow_flag) |=> !overflow_flag)
      else $error("overflow with short compare");
   chk_capb_enable:
      assert property (capture_b_irq |-> $past(ctrl[1]) && !$past(stopped))
      else $error("capture while disabled");
endmodule
bind tmr_timer16 tmr_asserts u_chk
(
   .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_a_irq(compare_a_irq),
   .capture_b_irq(capture_b_irq), .overflow_flag(overflow_flag)
);
`default_nettype wire

// *** verif/tmr_pin_model.sv ***
// Drives the two timer input pins.
// Assumes the bench sets levels on clk_sys; a glitch lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model
(
   input  wire logic clk_sys,
   input  wire logic level_a,
   input  wire logic level_b,
   input  wire logic glitch_a,
   output logic      event_input_a,
   output logic      capture_input_b
);
   // Pins follow the levels; a glitch flips pin A for one cycle
   always_ff @(posedge clk_sys)
   begin
      event_input_a   <= level_a ^ glitch_a;
      capture_input_b <= level_b;
   end
endmodule
`default_nettype wire

// *** verif/test_tmr_timer16.sv ***
// Self-checking bench for the timer.
// Assumes tmr_pin_model drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module test_tmr_timer16;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        pin_a;
   logic        pin_b;
   logic        level_a = 1'b0;
   logic        level_b = 1'b0;
   logic        glitch_a = 1'b0;
   logic        irq_a;
   logic        irq_b;
   logic        ovf;
   int          failures = 0;
   int          check_count = 0;
   int          c;
   logic [31:0] seed = 32'hf96c_00c0;
   logic [15:0] v1;
   logic [15:0] v2;
   logic [15:0] v3;
   // Clock
   always #2 clk_sys = ~clk_sys;
   tmr_timer16 #(.DATA_WIDTH(16)) uut
   (
      .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_input_a(pin_a),
      .capture_input_b(pin_b), .compare_a_irq(irq_a), .capture_b_irq(irq_b),
      .overflow_flag(ovf)
   );
   tmr_pin_model pins
   (
      .clk_sys(clk_sys), .level_a(level_a), .level_b(level_b), .glitch_a(glitch_a),
      .event_input_a(pin_a), .capture_input_b(pin_b)
   );
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Interval in clk_sys cycles for a clock select and compare value
   function automatic logic [15:0] exp_period(input int sel, input logic [15:0] n);
      return (n + 16'h0001) << (sel == 0 ? 0 : sel == 1 ? 2 : 8);
   endfunction
   // Event count left after p pulses for an edge code and compare n
   function automatic logic [15:0] exp_count(input logic [1:0] code, input int p, input int n);
      int e;
      e = code == tmr_pkg::EDGE_BOTH ? 2 * p : code == 2'h2 ? 0 : p;
      return 16'(e % (n + 1));
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   // Waits for compare request, capture request or overflow
   task automatic wait_sig(input int which, input int lim, output int n);
      n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (n < lim && (which == 0 ? irq_a : which == 1 ? irq_b : ovf) !== 1'b1);
      if (n >= lim)
         chk(16'h0000, 16'h0001);
   endtask
   task automatic wrap_up;
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      rd(tmr_pkg::ADDR_PRESCALER, v1);
      chk(v1, 16'(tmr_pkg::PRM_RESET));
      rd(3'h7, v1);
      chk(v1, 16'h0000);
      for (int s = 0; s < 3; s++)
      begin
         seed = xs(seed);
         v2 = s == 0 ? 16'h0001 : 16'(seed[1:0]) + 16'h0001;
         wr(tmr_pkg::ADDR_PRESCALER, 16'(s));
         wr(tmr_pkg::ADDR_CMP_CAP_A, v2);
         wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_CLEAR));
         wait_sig(0, 3000, c);
         wait_sig(0, 3000, c);
         chk(16'(c), exp_period(s, v2));
         wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_STOP));
      end
      // Compare lowered below the count: counting runs on past it
      wr(tmr_pkg::ADDR_PRESCALER, 16'h0000);
      wr(tmr_pkg::ADDR_CMP_CAP_A, 16'h0100);
      wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_CLEAR));
      repeat (40) @(posedge clk_sys);
      wr(tmr_pkg::ADDR_CMP_CAP_A, 16'h0004);
      rd(tmr_pkg::ADDR_COUNTER, v1);
      chk(16'(v1 > 16'h0020), 16'h0001);
      wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_STOP));
      wr(tmr_pkg::ADDR_CMP_CAP_A, 16'h0004);
      for (int k = 0; k < 4; k++)
      begin
         wr(tmr_pkg::ADDR_PRESCALER, 16'({k[1:0], 4'h3}));
         wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_CLEAR));
         repeat (3)
         begin
            level_a <= 1'b1;
            repeat (8) @(posedge clk_sys);
            level_a <= 1'b0;
            repeat (4) @(posedge clk_sys);
            glitch_a <= 1'b1;
            @(posedge clk_sys);
            glitch_a <= 1'b0;
            repeat (8) @(posedge clk_sys);
         end
         rd(tmr_pkg::ADDR_COUNTER, v1);
         chk(v1, exp_count(k[1:0], 3, 4));
         wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_STOP));
      end
      repeat (20) @(posedge clk_sys);
      wr(tmr_pkg::ADDR_PRESCALER, 16'h00F0);
      wr(tmr_pkg::ADDR_CAP_CMP_CTRL, 16'h0003);
      wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_FREE));
      for (int k = 0; k < 2; k++)
      begin
         seed = xs(seed);
         v2 = 16'(seed[4:0]) + 16'h000C;
         fork
            begin
               {level_b, level_a} <= k == 1 ? 2'b10 : 2'b01;
               repeat (v2) @(posedge clk_sys);
               {level_b, level_a} <= 2'b00;
            end
            begin
               wait_sig(1 - k, 200, c);
               rd(k == 1 ? tmr_pkg::ADDR_CMP_CAP_A : tmr_pkg::ADDR_CAPTURE_B, v1);
               wait_sig(1 - k, 200, c);
               rd(k == 1 ? tmr_pkg::ADDR_CMP_CAP_A : tmr_pkg::ADDR_CAPTURE_B, v3);
            end
         join
         chk(v3 - v1, v2);
      end
      wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_STOP));
      wr(tmr_pkg::ADDR_CAP_CMP_CTRL, 16'h0000);
      wr(tmr_pkg::ADDR_PRESCALER, 16'h0000);
      wr(tmr_pkg::ADDR_TIMER_MODE, 16'(tmr_pkg::MODE_FREE));
      wait_sig(2, 70000, c);
      chk(16'(c > 65530 && c < 65545), 16'h0001);
      repeat (30) @(posedge clk_sys);
      rd(tmr_pkg::ADDR_STATUS, v1);
      chk(v1, 16'h0001);
      wr(tmr_pkg::ADDR_STATUS, 16'h0001);
      rd(tmr_pkg::ADDR_STATUS, v1);
      chk(v1, 16'h0000);
      wrap_up;
   end
   // Hang guard: tests need about 70000 cycles, mostly the full wrap
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      failures++;
      wrap_up;
   end
endmodule
`default_nettype wire
